// >>> hdl/sgp_pkg.sv
// sgp_pkg: constants and carrier types of the serial gain control port.
// assumes a 32-bit ahb-lite register bus and a 7-bit gain code.
package sgp_pkg;

  // register byte offsets
  localparam logic [7:0] SGP_OFF_STATUS  = 8'h00;
  localparam logic [7:0] SGP_OFF_GAIN    = 8'h04;
  localparam logic [7:0] SGP_OFF_CTRL    = 8'h08;
  localparam logic [7:0] SGP_OFF_COMMITS = 8'h0C;
  localparam int         SGP_DEC_LSB     = 4;

  // control register field
  localparam int         SGP_CTRL_FORCE_DOWN_BIT = 0;

  // reset values
  localparam logic       SGP_FORCE_DOWN_RST = 1'h0;
  localparam logic       SGP_DOWN_RST       = 1'h1;
  localparam logic       SGP_HIZ_RST      = 1'h1;
  localparam logic [6:0] SGP_CODE_RST     = 7'h00;
  localparam logic [7:0] SGP_COMMITS_RST  = 8'h00;
  localparam logic [2:0] SGP_SYNC_RST     = 3'h7;

  // gain law, gain in units of 0.0001 db
  localparam logic [6:0]  SGP_CODE_MAX   = 7'h47;
  localparam logic [3:0]  SGP_COARSE_SAT = 4'h8;
  localparam logic [2:0]  SGP_FINE_TOP   = 3'h7;
  localparam logic [19:0] SGP_TOP_E4     = 20'h43238;
  localparam logic [19:0] SGP_STEP_E4    = 20'h01D66;

  // pins of the serial link
  typedef struct packed {
    logic load_window_n;
    logic serial_gain_bit;
  } sgp_link_type;

  // status register layout
  typedef struct packed {
    logic [20:0] zero;
    logic        window_open;
    logic        awake;
    logic        tx_enabled;
    logic        valid;
    logic [6:0]  code;
  } sgp_status_type;

endpackage

// >>> hdl/sgp_sync.sv
// sgp_sync: two-flop level synchroniser, one per bit.
// assumes inputs are slow levels from pins or another clock.
`timescale 1ns/1ps
module sgp_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

// >>> hdl/sgp_gain_map.sv
// sgp_gain_map: maps a 7-bit gain code to gain in 0.0001 db.
// assumes a purely combinational use, registered by the caller.
`timescale 1ns/1ps
module sgp_gain_map (
  input  wire logic [6:0]  code_in,
  output logic      [19:0] gain_e4_out
);

  logic [6:0]  eff;
  logic [6:0]  diff;
  logic [19:0] drop;

  always_comb begin
    // above the top code only the fine vernier steps remain
    if (code_in > sgp_pkg::SGP_CODE_MAX) begin
      eff = {sgp_pkg::SGP_COARSE_SAT, code_in[2:0]};
    end else begin
      eff = code_in;
    end
    diff        = sgp_pkg::SGP_CODE_MAX - eff;
    drop        = 20'(diff) * sgp_pkg::SGP_STEP_E4;
    gain_e4_out = sgp_pkg::SGP_TOP_E4 - drop;
  end

endmodule

// >>> hdl/sgp_port.sv
// sgp_port: serial gain port with power pins and ahb-lite registers.
// assumes the link clock stops outside load windows; ahb single words.
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module sgp_port (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  link_clk_in,
  input  wire sgp_pkg::sgp_link_type link_in,
  input  wire logic                  transmit_enable_n_in,
  input  wire logic                  sleep_n_in,
  input  wire logic                  hsel_in,
  input  wire logic [31:0]           haddr_in,
  input  wire logic [1:0]            htrans_in,
  input  wire logic                  hwrite_in,
  input  wire logic [2:0]            hsize_in,
  input  wire logic [31:0]           hwdata_in,
  input  wire logic                  hready_in,
  output logic                       hreadyout_out,
  output logic                       hresp_out,
  output logic      [31:0]           hrdata_out,
  output logic      [6:0]            gain_code_out,
  output logic      [19:0]           gain_e4_out,
  output logic                       gain_valid_out,
  output logic                       powered_down_out,
  output logic                       output_hiz_out
);

  // link domain
  logic       master_q;
  logic       capt_q;
  logic [6:0] shift_q;

  // core domain
  logic [2:0]  sync_w;
  logic        win_s;
  logic        te_s;
  logic        slp_s;
  logic        win_prev_q;
  logic        commit;
  logic [6:0]  gain_q;
  logic [19:0] gain_e4_q;
  logic [19:0] map_e4;
  logic        valid_q;
  logic        down_q;
  logic        hiz_q;
  logic        force_down_q;
  logic [7:0]  commits_q;

  // bus
  logic        acc;
  logic        hit;
  logic        wr_q;
  logic [7:0]  waddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  sgp_pkg::sgp_status_type status;

  // ---------------------------------------------------------------
  // link side: runs only on the controller's clock, no reset

  // master stage: bit taken on rising edge while the window is open
  always_ff @(posedge link_clk_in) begin
    capt_q <= !link_in.load_window_n;
    if (!link_in.load_window_n) begin
      master_q <= link_in.serial_gain_bit;
    end
  end

  // slave stage: seven stages, oldest bit drops off the top
  // no reset here; contents unknown until a full load
  always_ff @(negedge link_clk_in) begin
    if (capt_q) begin
      shift_q <= {shift_q[5:0], master_q};
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers into the core clock

  sgp_sync #(
    .W   (3),
    .RST (sgp_pkg::SGP_SYNC_RST)
  ) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({link_in.load_window_n, transmit_enable_n_in, sleep_n_in}),
    .q_out  (sync_w)
  );

  assign win_s = sync_w[2];
  assign te_s  = sync_w[1];
  assign slp_s = sync_w[0];

  // ---------------------------------------------------------------
  // commit on rising window

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_prev_q <= 1'h1;
    end else begin
      win_prev_q <= win_s;
    end
  end

  // shift_q is quiet while the window is high, so the word is stable
  // by the time the synchronised edge arrives here
  assign commit = win_s && !win_prev_q;

  sgp_gain_map u_map (
    .code_in     (shift_q),
    .gain_e4_out (map_e4)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gain_q    <= sgp_pkg::SGP_CODE_RST;
      gain_e4_q <= '0;
      valid_q   <= 1'h0;
    end else if (commit) begin
      // only seven bits exist, so codes above 127 alias below
      gain_q    <= shift_q;
      gain_e4_q <= map_e4;
      valid_q   <= 1'h1;
    end
  end

  // commit counter: a commit beats a software clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      commits_q <= sgp_pkg::SGP_COMMITS_RST;
    end else if (commit) begin
      commits_q <= commits_q + 8'h01;
    end else if (wr_q && hit_w(waddr_q, sgp_pkg::SGP_OFF_COMMITS)) begin
      commits_q <= sgp_pkg::SGP_COMMITS_RST;
    end
  end

  // ---------------------------------------------------------------
  // power state, held powered down through reset

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      down_q <= sgp_pkg::SGP_DOWN_RST;
      hiz_q  <= sgp_pkg::SGP_HIZ_RST;
    end else begin
      down_q <= !te_s || force_down_q;
      hiz_q  <= !slp_s;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states

  function automatic logic hit_w(input logic [7:0] a,
                                 input logic [7:0] off);
    hit_w = (a == off);
  endfunction

  assign acc = hsel_in && htrans_in[1] && hready_in;
  assign hit = (haddr_in[31:sgp_pkg::SGP_DEC_LSB] == '0);

  always_comb begin
    status             = '0;
    status.code        = gain_q;
    status.valid       = valid_q;
    status.tx_enabled  = te_s;
    status.awake       = slp_s;
    status.window_open = !win_s;
    rd_mux             = 32'h0000_0000;
    if (hit) begin
      case (haddr_in[7:0])
        sgp_pkg::SGP_OFF_STATUS: begin
          rd_mux = status;
        end
        sgp_pkg::SGP_OFF_GAIN: begin
          rd_mux = {{12{gain_e4_q[19]}}, gain_e4_q};
        end
        sgp_pkg::SGP_OFF_CTRL: begin
          rd_mux = {31'h0000_0000, force_down_q};
        end
        sgp_pkg::SGP_OFF_COMMITS: begin
          rd_mux = {24'h00_0000, commits_q};
        end
        default: begin
          rd_mux = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data registered in the address phase for a clean data phase
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q     <= 1'h0;
      waddr_q  <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      // writes outside the decoded range are dropped by leaving wr_q low
      wr_q <= acc && hwrite_in && hit;
      if (acc) begin
        waddr_q <= haddr_in[7:0];
      end
      if (acc && !hwrite_in) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      force_down_q <= sgp_pkg::SGP_FORCE_DOWN_RST;
    end else if (wr_q && hit_w(waddr_q, sgp_pkg::SGP_OFF_CTRL)) begin
      force_down_q <= hwdata_in[sgp_pkg::SGP_CTRL_FORCE_DOWN_BIT];
    end
  end

  assign hreadyout_out    = 1'h1;
  assign hresp_out        = 1'h0;
  assign hrdata_out       = hrdata_q;
  assign gain_code_out    = gain_q;
  assign gain_e4_out      = gain_e4_q;
  assign gain_valid_out   = valid_q;
  assign powered_down_out = down_q;
  assign output_hiz_out   = hiz_q;

  // ---------------------------------------------------------------
  // checks

  property p_down_follows_pin;
    @(posedge clk_in) disable iff (rst_in)
    !te_s |=> powered_down_out;
  endproperty
  a_down_follows_pin: assert property (p_down_follows_pin)
    else $error("transmit enable low did not power down");

  // sampled reset keeps the release edge out of the antecedent
  property p_down_release;
    @(posedge clk_in) disable iff (rst_in)
    (!rst_in && te_s && !force_down_q) |=> !powered_down_out;
  endproperty
  a_down_release: assert property (p_down_release)
    else $error("amplifier stayed down with transmit enabled");

  property p_sleep_hiz;
    @(posedge clk_in) disable iff (rst_in)
    !rst_in |=> output_hiz_out == !$past(slp_s);
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz)
    else $error("sleep pin not reflected on output state");

  property p_gain_only_on_commit;
    @(posedge clk_in) disable iff (rst_in)
    $changed(gain_q) |-> $past(commit);
  endproperty
  a_gain_only_on_commit: assert property (p_gain_only_on_commit)
    else $error("gain changed without a commit");

  property p_commit_copies;
    @(posedge clk_in) disable iff (rst_in)
    commit |=> (gain_q == $past(shift_q)) && gain_valid_out;
  endproperty
  a_commit_copies: assert property (p_commit_copies)
    else $error("commit did not copy the shift register");

  property p_hold_while_open;
    @(posedge clk_in) disable iff (rst_in)
    !win_s |=> $stable(gain_q) && $stable(gain_e4_q);
  endproperty
  a_hold_while_open: assert property (p_hold_while_open)
    else $error("gain moved while the load window was open");

  property p_gain_law;
    @(posedge clk_in) disable iff (rst_in)
    (valid_q && gain_q <= sgp_pkg::SGP_CODE_MAX) |->
      gain_e4_q == sgp_pkg::SGP_TOP_E4 -
        20'(sgp_pkg::SGP_CODE_MAX - gain_q) * sgp_pkg::SGP_STEP_E4;
  endproperty
  a_gain_law: assert property (p_gain_law)
    else $error("gain value wrong for a valid code");

  property p_sawtooth;
    @(posedge clk_in) disable iff (rst_in)
    (valid_q && gain_q > sgp_pkg::SGP_CODE_MAX) |->
      gain_e4_q == sgp_pkg::SGP_TOP_E4 -
        20'(sgp_pkg::SGP_FINE_TOP - gain_q[2:0]) * sgp_pkg::SGP_STEP_E4;
  endproperty
  a_sawtooth: assert property (p_sawtooth)
    else $error("gain value wrong above the top code");

  // link side has no reset, so no disable here
  property p_slave_takes_master;
    @(negedge link_clk_in)
    capt_q |=> shift_q[0] == $past(master_q);
  endproperty
  a_slave_takes_master: assert property (p_slave_takes_master)
    else $error("slave stage missed the master bit");

  // stages start unknown, so compare only once six are filled
  property p_shift_seven;
    @(negedge link_clk_in)
    capt_q [*7] |=> shift_q[6:1] == $past(shift_q[5:0]);
  endproperty
  a_shift_seven: assert property (p_shift_seven)
    else $error("shift register did not move up by one");

  c_commit: cover property (@(posedge clk_in) disable iff (rst_in)
    commit);
  c_top_code: cover property (@(posedge clk_in) disable iff (rst_in)
    commit ##1 gain_q > sgp_pkg::SGP_CODE_MAX);
  c_power_up: cover property (@(posedge clk_in) disable iff (rst_in)
    $fell(powered_down_out) && gain_valid_out);

endmodule

// >>> sim/sgp_ctrl_model.sv
// sgp_ctrl_model: controller side of the serial gain link.
// assumes the bench calls send; the link clock idles low between frames.
`timescale 1ns/1ps
module sgp_ctrl_model (
  output logic                  link_clk_out,
  output sgp_pkg::sgp_link_type link_out
);
  initial begin
    link_clk_out = 1'b0;
    link_out     = 2'b10;
  end

  // n pulses, bits msb first; n above seven pushes early bits out
  task automatic send(input logic [15:0] word, input int n);
    // odd offset keeps link edges off the core clock edges
    #7.3 link_out.load_window_n = 1'b0;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      link_out.serial_gain_bit = word[i];
      #40 link_clk_out = 1'b1;
      #40 link_clk_out = 1'b0;
    end
    #20 link_out.load_window_n = 1'b1;
    // released line shows no stale bit
    link_out.serial_gain_bit = ~link_out.serial_gain_bit;
  endtask
endmodule

// >>> sim/serial_gain_control_port_bench.sv
// serial_gain_control_port_bench: self-checking bench of sgp_port.
// assumes a zero-wait ahb slave and a 3 to 4 edge commit latency.
`timescale 1ns/1ps
module serial_gain_control_port_bench;
  logic                  clk_in;
  logic                  rst_in;
  logic                  transmit_enable_n;
  logic                  sleep_n;
  logic                  link_clk;
  sgp_pkg::sgp_link_type link;
  logic                  hsel;
  logic                  hwrite;
  logic                  hready;
  logic                  hreadyout;
  logic                  hresp;
  logic                  gain_valid;
  logic                  powered_down;
  logic                  hiz;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic [31:0]           rd;
  logic [6:0]            gain_code;
  logic [19:0]           gain_e4;
  int                    miscompares;
  int                    checks;
  int                    cycles;
  int                    loads;

  assign hready = hreadyout;

  sgp_ctrl_model ctrl (.link_clk_out(link_clk), .link_out(link));

  sgp_port dut (
    .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
    .link_in(link), .transmit_enable_n_in(transmit_enable_n),
    .sleep_n_in(sleep_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
    .gain_code_out(gain_code), .gain_e4_out(gain_e4),
    .gain_valid_out(gain_valid), .powered_down_out(powered_down),
    .output_hiz_out(hiz));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_in);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
  endtask

  // sawtooth above 71 folds onto the fine steps below the top
  function automatic logic [19:0] gain_of(input logic [6:0] code);
    int c;
    c = code;
    if (c > 71) c = 64 + c % 8;
    return 20'(275000 - 7526 * (71 - c));
  endfunction

  task automatic load(input logic [15:0] w, input int n,
                      input logic [6:0] code);
    ctrl.send(w, n);
    loads++;
    repeat (6) @(posedge clk_in);
    chk(gain_code, code);
    chk(gain_e4, gain_of(code));
    chk(gain_valid, 1'b1);
  endtask

  task automatic t_power();
    transmit_enable_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk(powered_down, 1'b1);
    load(16'h0010, 8, 7'h10);
    transmit_enable_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk(powered_down, 1'b0);
    sleep_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk(hiz, 1'b1);
    sleep_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk(hiz, 1'b0);
    ahb(1'b1, sgp_pkg::SGP_OFF_CTRL, 32'h1);
    repeat (4) @(posedge clk_in);
    chk(powered_down, 1'b1);
    ahb(1'b0, sgp_pkg::SGP_OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b1, sgp_pkg::SGP_OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    chk(powered_down, 1'b0);
    $display("test power done");
  endtask

  task automatic t_codes();
    logic [7:0] tbl [7] = '{8'h47, 8'h00, 8'h23, 8'h48, 8'h4F,
                            8'h7F, 8'hC7};
    logic [19:0] g;
    for (int i = 0; i < 7; i++) begin
      load({8'h00, tbl[i]}, 8, tbl[i][6:0]);
      ahb(1'b0, sgp_pkg::SGP_OFF_GAIN, 32'h0);
      g = gain_of(tbl[i][6:0]);
      chk(rd, {{12{g[19]}}, g});
      ahb(1'b0, sgp_pkg::SGP_OFF_STATUS, 32'h0);
      chk(rd, {21'h0, 4'h7, tbl[i][6:0]});
    end
    ahb(1'b0, sgp_pkg::SGP_OFF_COMMITS, 32'h0);
    chk(rd, 32'(loads));
    ahb(1'b1, sgp_pkg::SGP_OFF_COMMITS, 32'h0);
    ahb(1'b0, sgp_pkg::SGP_OFF_COMMITS, 32'h0);
    chk(rd, 32'h0);
    loads = 0;
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    $display("test codes done");
  endtask

  task automatic t_hold();
    load(16'h0047, 8, 7'h47);
    fork
      ctrl.send(16'h0005, 8);
      begin
        #332;
        chk(gain_code, 7'h47);
        chk(gain_e4, gain_of(7'h47));
      end
    join
    repeat (6) @(posedge clk_in);
    chk(gain_code, 7'h05);
    load(16'h012A, 9, 7'h2A);
    $display("test hold done");
  endtask

  initial begin
    rst_in            = 1'b1;
    transmit_enable_n = 1'b1;
    sleep_n           = 1'b1;
    hsel              = 1'b1;
    hsize             = 3'h2;
    htrans            = 2'h0;
    haddr             = 32'h0;
    hwrite            = 1'b0;
    hwdata            = 32'h0;
    miscompares       = 0;
    checks            = 0;
    loads             = 0;
    repeat (16) @(posedge clk_in);
    chk(powered_down, 1'b1);
    chk(hiz, 1'b1);
    chk(gain_valid, 1'b0);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk(powered_down, 1'b0);
    chk(hiz, 1'b0);
    ahb(1'b0, sgp_pkg::SGP_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, sgp_pkg::SGP_OFF_COMMITS, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    t_power();
    t_codes();
    t_hold();
    results();
  end
endmodule
